// >>> dv/srf_cfg_chk.sv
module srf_cfg_chk (
  input wire logic       clk_i,
  input wire logic       srst_i,
  input wire logic       cs_n_i,
  input wire logic       rs_i,
  input wire logic       rd_n_i,
  input wire logic       data_oe_o,
  input wire logic [1:0] nv_op_o,
  input wire logic       nv_op_start_o,
  input wire logic       int_program_supply_o,
  input wire logic       ext_program_supply_o,
  input wire logic       osc_boost_sel_o,
  input wire logic [9:0] ref_multiplier_out_o,
  input wire logic [9:0] ref_divisor_o,
  input wire logic [8:0] ram_row_index_o,
  input wire logic [8:0] icon_common_a_o,
  input wire logic [8:0] icon_common_b_o,
  input wire logic       line_tick_o,
  input wire logic       frame_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // Three held cycles cover the two-stage synchroniser
  sequence s_read_held;
    (!cs_n_i && rs_i && !rd_n_i) [*3];
  endsequence
  sequence s_reset_left;
    $fell(srst_i);
  endsequence
  a_oe_follows_read: assert property (s_read_held |=> data_oe_o)
    else $error("read enable missing");
  a_oe_needs_read: assert property (data_oe_o |-> $past(!cs_n_i && rs_i && !rd_n_i, 2))
    else $error("read enable without request");
  a_reset_values: assert property (s_reset_left |-> nv_op_o == 2'b11 && !osc_boost_sel_o
    && ref_multiplier_out_o == 10'h17D && ram_row_index_o == 9'h000)
    else $error("reset values wrong");
  a_start_not_rsvd: assert property (nv_op_start_o |=> nv_op_o != 2'b11)
    else $error("reserved selector started");
  a_start_one_cycle: assert property (nv_op_start_o |=> !nv_op_start_o)
    else $error("start pulse too long");
  a_supply_exclusive: assert property (!(int_program_supply_o && ext_program_supply_o))
    else $error("both supplies on");
  a_supply_needs_op: assert property ((int_program_supply_o || ext_program_supply_o) |->
    nv_op_o inside {2'b01, 2'b10} || $past(nv_op_o) inside {2'b01, 2'b10})
    else $error("supply on while idle");
  a_icon_rows_fixed: assert property (icon_common_a_o == 9'h0A0 && icon_common_b_o == 9'h0A1)
    else $error("icon rows moved");
  a_divisor_fixed: assert property (ref_divisor_o == 10'h17D)
    else $error("divisor wrong");
  a_row_in_range: assert property (ram_row_index_o < 9'h0A0)
    else $error("row past wrap");
  a_frame_ends_line: assert property (frame_o |-> line_tick_o)
    else $error("frame off line end");
  a_line_pulse_short: assert property (line_tick_o |=> !line_tick_o)
    else $error("line pulse too long");
endmodule

bind srf_cfg_top srf_cfg_chk u_chk (
  .clk_i(clk_i), .srst_i(srst_i), .cs_n_i(cs_n_i), .rs_i(rs_i), .rd_n_i(rd_n_i),
  .data_oe_o(data_oe_o), .nv_op_o(nv_op_o), .nv_op_start_o(nv_op_start_o),
  .int_program_supply_o(int_program_supply_o), .ext_program_supply_o(ext_program_supply_o),
  .osc_boost_sel_o(osc_boost_sel_o), .ref_multiplier_out_o(ref_multiplier_out_o),
  .ref_divisor_o(ref_divisor_o), .ram_row_index_o(ram_row_index_o),
  .icon_common_a_o(icon_common_a_o), .icon_common_b_o(icon_common_b_o),
  .line_tick_o(line_tick_o), .frame_o(frame_o)
);

// >>> dv/srf_host_model.sv
module srf_host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output logic            cs_n_o,
  output logic            rs_o,
  output logic            wr_n_o,
  output logic            rd_n_o,
  output logic [7:0]      data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cs_n_o = 1'b1;
    rs_o = 1'b0;
    wr_n_o = 1'b1;
    rd_n_o = 1'b1;
    data_o = 8'h00;
  end
  // Four clocks per phase: the pins cross a two-stage synchroniser
  task automatic wr(input logic [7:0] b);
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    rs_o <= 1'b1;
    data_o <= b;
    wr_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    wr_n_o <= 1'b1;
    repeat (4) @(posedge clk_i);
    cs_n_o <= 1'b1;
    rs_o <= 1'b0;
    data_o <= ~b; // Released bus must not show the old byte
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    wr(8'hF4);
    wr({4'hD, a});
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    rs_o <= 1'b1;
    rd_n_o <= 1'b0;
    repeat (6) @(posedge clk_i);
    v = rdata_i;
    rd_n_o <= 1'b1;
    cs_n_o <= 1'b1;
    rs_o <= 1'b0;
  endtask
  task automatic mirror();
    wr(8'hF0);
    wr(8'h8D);
    wr(8'h22);
    wr(8'hF4);
    wr(8'h63);
  endtask
endmodule

// >>> dv/stn_row_map_frame_timing_cfg_test.sv
module stn_row_map_frame_timing_cfg_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_i = 1'b0;
  logic       srst_i = 1'b1;
  logic       ext_clock_in_i = 1'b0;
  logic       ce_i = 1'b1;
  logic       ext_clock_sel_i = 1'b1;
  logic       cs_n_i, rs_i, wr_n_i, rd_n_i, data_oe_o, nv_op_start_o;
  logic       int_sup, ext_sup, osc_boost, line_tick_o, frame_o, display_on_o;
  logic [7:0] data_i, data_o, com_pos_o, v;
  logic [1:0] nv_op_o;
  logic [9:0] mult, divisor;
  logic [8:0] row, icon_a, icon_b;
  int         n_mismatch = 0;
  int         n_checks = 0;
  int         n_start = 0;
  int         n, k;
  always #20 clk_i = ~clk_i;
  always begin
    repeat (2) @(posedge clk_i);
    ext_clock_in_i <= ~ext_clock_in_i;
  end
  always @(posedge clk_i) if (nv_op_start_o === 1'b1) n_start <= n_start + 1;
  srf_host_model host (.clk_i(clk_i), .rdata_i(data_o), .cs_n_o(cs_n_i), .rs_o(rs_i),
    .wr_n_o(wr_n_i), .rd_n_o(rd_n_i), .data_o(data_i));
  srf_cfg_top DUT (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .cs_n_i(cs_n_i),
    .rs_i(rs_i), .wr_n_i(wr_n_i), .rd_n_i(rd_n_i), .data_i(data_i), .data_o(data_o),
    .data_oe_o(data_oe_o), .ext_clock_in_i(ext_clock_in_i), .ext_clock_sel_i(ext_clock_sel_i),
    .nv_op_o(nv_op_o), .nv_op_start_o(nv_op_start_o), .int_program_supply_o(int_sup),
    .ext_program_supply_o(ext_sup), .osc_boost_sel_o(osc_boost),
    .ref_multiplier_out_o(mult), .ref_divisor_o(divisor), .ram_row_index_o(row),
    .com_pos_o(com_pos_o), .icon_common_a_o(icon_a), .icon_common_b_o(icon_b),
    .line_tick_o(line_tick_o), .frame_o(frame_o), .display_on_o(display_on_o));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Edge count to the next frame or line pulse, sampled after the edge settles
  task automatic wait_evt(input bit frm, output int c);
    c = 0;
    do begin
      @(posedge clk_i);
      #1;
      c++;
    end while (!(frm ? frame_o === 1'b1 : line_tick_o === 1'b1) && c < 30000);
    if (c >= 30000) begin
      n_mismatch++;
      print_verdict();
    end
  endtask
  task automatic t_reset();
    chk(nv_op_o, 16'h0003);
    chk(mult, 16'h017D);
    chk(icon_a, 16'h00A0);
    chk(icon_b, 16'h00A1);
    host.rd(4'hA, v);
    chk(v, 16'h000C);
    host.rd(4'hB, v);
    chk(v, 16'h0000);
    $display("test reset done");
  endtask
  task automatic t_trim();
    logic [3:0] codes[4] = '{4'h7, 4'h0, 4'h8, 4'hF};
    logic [9:0] exps[4] = '{10'h184, 10'h17D, 10'h175, 10'h17C};
    for (int i = 0; i < 4; i++) begin
      host.wr(8'hF5);
      host.wr({4'hB, codes[i]});
      repeat (4) @(posedge clk_i);
      chk(mult, exps[i]);
      host.rd(4'hB, v);
      chk(v, {12'h000, codes[i]});
    end
    $display("test trim done");
  endtask
  // Frozen clock enable must swallow a whole command
  task automatic t_freeze();
    wait_evt(0, n);
    @(posedge clk_i);
    ce_i <= 1'b0;
    host.wr(8'hF5);
    host.wr(8'hB3);
    repeat (4) @(posedge clk_i);
    ce_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk(mult, 16'h017C);
    $display("test freeze done");
  endtask
  task automatic t_volume();
    host.wr(8'hF2);
    host.wr(8'h83);
    repeat (4) @(posedge clk_i);
    chk(mult, 16'h017C);
    host.wr(8'h95);
    repeat (4) @(posedge clk_i);
    chk(mult, 16'h01B1);
    host.wr(8'h87);
    host.wr(8'h9F);
    repeat (4) @(posedge clk_i);
    chk(mult, 16'h01FB);
    $display("test volume done");
  endtask
  task automatic t_nv();
    logic [1:0] op;
    for (int i = 0; i < 4; i++) begin
      op = 2'(i);
      k = n_start;
      host.wr(8'hF5);
      host.wr({4'hA, op, op[1], op[0]});
      repeat (4) @(posedge clk_i);
      chk(nv_op_o, op);
      chk(16'(n_start - k), op != 2'b11);
      chk(int_sup, (op == 2'b01 || op == 2'b10) && !op[1]);
      chk(ext_sup, (op == 2'b01 || op == 2'b10) && op[1]);
      chk(osc_boost, op[0]);
      host.rd(4'hA, v);
      chk(v, {12'h000, op, op[1], op[0]});
    end
    $display("test nv mode done");
  endtask
  task automatic t_frame();
    host.wr(8'hF4);
    host.wr(8'h70);
    host.wr(8'h61);
    host.wr(8'hF0);
    host.wr(8'h87);
    host.wr(8'h4F);
    host.wr(8'h59);
    wait_evt(1'b1, n);
    wait_evt(0, n);
    chk(n, 16'd448);
    wait_evt(1'b1, n);
    repeat (3) @(posedge clk_i);
    chk(row, 16'd159);
    chk(com_pos_o, 16'd15);
    k = 1;
    wait_evt(0, n);
    repeat (3) @(posedge clk_i);
    chk(row, 16'd0);
    chk(com_pos_o, 16'd16);
    while (frame_o !== 1'b1 && k < 300) begin
      wait_evt(0, n);
      k++;
    end
    chk(k, 16'd10);
    host.wr(8'h8F);
    host.wr(8'h40);
    host.wr(8'h50);
    wait_evt(1'b1, n);
    repeat (3) @(posedge clk_i);
    chk(row, 16'd0);
    chk(com_pos_o, 16'd114);
    host.mirror();
    wait_evt(1'b1, n);
    wait_evt(0, n);
    chk(n, 16'd1984);
    wait_evt(1'b1, n);
    repeat (3) @(posedge clk_i);
    chk(com_pos_o, 16'd84);
    chk(display_on_o, 1'b1);
    $display("test frame done");
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    t_reset();
    t_trim();
    t_freeze();
    t_volume();
    t_nv();
    t_frame();
    print_verdict();
  end
endmodule

// >>> logic/srf_cfg_top.sv
module srf_cfg_top #(
  parameter int OSC_HALF_PERIODS = 4
) (
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        ce_i,
  input  wire logic        cs_n_i,
  input  wire logic        rs_i,
  input  wire logic        wr_n_i,
  input  wire logic        rd_n_i,
  input  wire logic [7:0]  data_i,
  output logic [7:0]       data_o,
  output logic             data_oe_o,
  input  wire logic        ext_clock_in_i,
  input  wire logic        ext_clock_sel_i,
  output logic [1:0]       nv_op_o,
  output logic             nv_op_start_o,
  output logic             int_program_supply_o,
  output logic             ext_program_supply_o,
  output logic             osc_boost_sel_o,
  output logic [9:0]       ref_multiplier_out_o,
  output logic [9:0]       ref_divisor_o,
  output logic [8:0]       ram_row_index_o,
  output logic [7:0]       com_pos_o,
  output logic [8:0]       icon_common_a_o,
  output logic [8:0]       icon_common_b_o,
  output logic             line_tick_o,
  output logic             frame_o,
  output logic             display_on_o
);

  localparam int SW = 14;
  localparam logic [SW-1:0] SYNC_RST = {1'b1, 1'b0, 1'b1, 1'b1, 8'h00, 1'b0, 1'b0};

  // Pin synchronisers; only stage two and later are looked at
  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;
  logic [SW-1:0] raw_pins;
  logic          wr_n_d3_q;
  logic          ck_d3_q;

  assign raw_pins = {cs_n_i, rs_i, wr_n_i, rd_n_i, data_i, ext_clock_in_i, ext_clock_sel_i};

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sync1_q   <= SYNC_RST;
      sync2_q   <= SYNC_RST;
      wr_n_d3_q <= 1'b1;
      ck_d3_q   <= 1'b0;
    end else if (ce_i) begin
      sync1_q   <= raw_pins;
      sync2_q   <= sync1_q;
      wr_n_d3_q <= sync2_q[11];
      ck_d3_q   <= sync2_q[1];
    end
  end

  logic       s_cs_n;
  logic       s_rs;
  logic       s_wr_n;
  logic       s_rd_n;
  logic [7:0] s_data;
  logic       s_ck;
  logic       s_ck_sel;

  assign s_cs_n   = sync2_q[13];
  assign s_rs     = sync2_q[12];
  assign s_wr_n   = sync2_q[11];
  assign s_rd_n   = sync2_q[10];
  assign s_data   = sync2_q[9:2];
  assign s_ck     = sync2_q[1];
  assign s_ck_sel = sync2_q[0];

  // Command taken on the rising edge of the write strobe
  logic       cmd_stb;
  logic [3:0] cmd_op;
  logic [3:0] cmd_arg;

  assign cmd_stb = ce_i && !s_cs_n && s_rs && s_wr_n && !wr_n_d3_q;
  assign cmd_op  = s_data[7:4];
  assign cmd_arg = s_data[3:0];

  logic [2:0] bank_q;
  logic [3:0] rd_addr_q;
  logic [3:0] nv_mode_q;
  logic [3:0] trim_q;
  logic [2:0] vol_hi_q;
  logic [6:0] volume_q;
  logic [3:0] disp_ctl_q;
  logic [7:0] start_line_q;
  logic [3:0] start_com_q;
  logic [3:0] duty_q;

  function automatic logic hit(input logic [2:0] bank, input logic [2:0] want,
                               input logic [3:0] op, input logic [3:0] want_op);
    hit = (bank == want) && (op == want_op);
  endfunction

  logic w_bank;
  logic w_rd_addr;
  logic w_nv;
  logic w_trim;
  logic w_vol_hi;
  logic w_vol_lo;
  logic w_disp;
  logic w_line_lo;
  logic w_line_hi;
  logic w_start_com;
  logic w_duty;

  assign w_bank      = cmd_stb && (cmd_op == srf_pkg::CMD_BANK);
  assign w_rd_addr   = cmd_stb && hit(bank_q, srf_pkg::BANK_SYS, cmd_op, srf_pkg::CMD_RD_ADDR);
  assign w_nv        = cmd_stb && hit(bank_q, srf_pkg::BANK_EXT, cmd_op, srf_pkg::CMD_NV_MODE);
  assign w_trim      = cmd_stb && hit(bank_q, srf_pkg::BANK_EXT, cmd_op, srf_pkg::CMD_TRIM);
  assign w_vol_hi    = cmd_stb && hit(bank_q, srf_pkg::BANK_VOL, cmd_op, srf_pkg::CMD_VOL_HI);
  assign w_vol_lo    = cmd_stb && hit(bank_q, srf_pkg::BANK_VOL, cmd_op, srf_pkg::CMD_VOL_LO);
  assign w_disp      = cmd_stb && hit(bank_q, srf_pkg::BANK_DISP, cmd_op, srf_pkg::CMD_DISP_CTL);
  assign w_line_lo   = cmd_stb && hit(bank_q, srf_pkg::BANK_DISP, cmd_op, srf_pkg::CMD_LINE_LO);
  assign w_line_hi   = cmd_stb && hit(bank_q, srf_pkg::BANK_DISP, cmd_op, srf_pkg::CMD_LINE_HI);
  assign w_start_com = cmd_stb && hit(bank_q, srf_pkg::BANK_SYS, cmd_op, srf_pkg::CMD_START_COM);
  assign w_duty      = cmd_stb && hit(bank_q, srf_pkg::BANK_SYS, cmd_op, srf_pkg::CMD_DUTY);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      bank_q       <= srf_pkg::RST_BANK;
      rd_addr_q    <= srf_pkg::RST_RD_ADDR;
      nv_mode_q    <= srf_pkg::RST_NV_MODE;
      trim_q       <= srf_pkg::RST_TRIM;
      vol_hi_q     <= 3'h0;
      volume_q     <= srf_pkg::RST_VOLUME;
      disp_ctl_q   <= 4'h0;
      start_line_q <= 8'h00;
      start_com_q  <= 4'h0;
      duty_q       <= srf_pkg::RST_DUTY;
    end else if (ce_i) begin
      if (w_bank) bank_q <= cmd_arg[2:0];
      if (w_rd_addr) rd_addr_q <= cmd_arg;
      if (w_nv) nv_mode_q <= cmd_arg;
      if (w_trim) trim_q <= cmd_arg;
      if (w_vol_hi) vol_hi_q <= cmd_arg[2:0];
      // Volume only changes once both parts are in, avoiding a transient level
      if (w_vol_lo) volume_q <= {vol_hi_q, cmd_arg};
      if (w_disp) disp_ctl_q <= cmd_arg;
      if (w_line_lo) start_line_q[3:0] <= cmd_arg;
      if (w_line_hi) start_line_q[7:4] <= cmd_arg;
      if (w_start_com) start_com_q <= cmd_arg;
      if (w_duty) duty_q <= cmd_arg;
    end
  end

  // Non-volatile operation control
  logic [1:0] nv_op;
  logic       nv_pe;

  assign nv_op = {nv_mode_q[srf_pkg::NV_OP_HI_POS], nv_mode_q[srf_pkg::NV_OP_LO_POS]};
  assign nv_pe = (nv_op == srf_pkg::SRF_NV_PROGRAM) || (nv_op == srf_pkg::SRF_NV_ERASE);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      nv_op_o              <= srf_pkg::RST_NV_MODE[3:2];
      nv_op_start_o        <= 1'b0;
      int_program_supply_o <= 1'b0;
      ext_program_supply_o <= 1'b0;
    end else if (ce_i) begin
      nv_op_o              <= nv_op;
      // Reserved code never launches anything
      nv_op_start_o        <= w_nv && ({cmd_arg[3], cmd_arg[2]} != srf_pkg::SRF_NV_RSVD);
      int_program_supply_o <= nv_pe && !nv_mode_q[srf_pkg::NV_SUPPLY_POS];
      ext_program_supply_o <= nv_pe && nv_mode_q[srf_pkg::NV_SUPPLY_POS];
    end
  end

  assign osc_boost_sel_o = nv_mode_q[srf_pkg::NV_BOOST_POS];

  // Internal oscillator: phase step 2 normal, 3 boosted, giving exactly +50%
  logic [7:0] osc_acc_q;
  logic [7:0] osc_step;
  logic [7:0] osc_top;
  logic       osc_tick;

  assign osc_step = osc_boost_sel_o ? 8'd3 : 8'd2;
  assign osc_top  = 8'(2 * OSC_HALF_PERIODS);
  assign osc_tick = (osc_acc_q + osc_step) >= osc_top;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      osc_acc_q <= 8'h00;
    end else if (ce_i) begin
      osc_acc_q <= osc_tick ? osc_acc_q + osc_step - osc_top : osc_acc_q + osc_step;
    end
  end

  // Source selection; external clock counted on its rising edge
  logic src_tick;
  logic [7:0] line_idx_o_w;

  assign src_tick = s_ck_sel ? (s_ck && !ck_d3_q) : osc_tick;

  srf_frame_gen u_frame (
    .clk_i       (clk_i),
    .srst_i      (srst_i),
    .ce_i        (ce_i),
    .src_tick_i  (src_tick),
    .duty_code_i (duty_q),
    .grad_i      (srf_pkg::srf_grad_t'(disp_ctl_q[srf_pkg::DC_GRAD_POS +: 2])),
    .line_tick_o (line_tick_o),
    .frame_o     (frame_o),
    .line_idx_o  (line_idx_o_w)
  );

  // Row mapping
  logic [8:0] row_sum;
  logic [8:0] row_wrap;
  logic [7:0] com_fwd;
  logic [7:0] com_sel;

  assign row_sum  = {1'b0, start_line_q} + {1'b0, line_idx_o_w};
  // Sum reaches at most 384, so two subtractions cover every case
  assign row_wrap = (row_sum >= 2 * srf_pkg::ROW_COUNT) ? row_sum - 9'(2 * srf_pkg::ROW_COUNT) :
                    (row_sum >= srf_pkg::ROW_COUNT) ? row_sum - srf_pkg::ROW_COUNT : row_sum;
  assign com_fwd  = 8'(start_com_q * srf_pkg::COM_STEP) + line_idx_o_w;
  assign com_sel  = disp_ctl_q[srf_pkg::DC_SHIFT_POS] ?
                    srf_pkg::COM_COUNT - 8'd1 - com_fwd : com_fwd;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ram_row_index_o <= 9'h000;
      com_pos_o       <= 8'h00;
      icon_common_a_o <= srf_pkg::ICON_ROW_A;
      icon_common_b_o <= srf_pkg::ICON_ROW_B;
    end else if (ce_i) begin
      ram_row_index_o <= row_wrap;
      com_pos_o       <= com_sel;
      icon_common_a_o <= srf_pkg::ICON_ROW_A;
      icon_common_b_o <= srf_pkg::ICON_ROW_B;
    end
  end

  // Effective volume: signed sum of code and trim, over a fixed divisor
  logic signed [9:0] trim_sx;
  logic signed [9:0] vol_sum;

  assign trim_sx = 10'(signed'(trim_q));
  assign vol_sum = signed'({3'h0, volume_q}) + trim_sx;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ref_multiplier_out_o <= srf_pkg::VOL_DIVISOR;
      ref_divisor_o        <= srf_pkg::VOL_DIVISOR;
    end else if (ce_i) begin
      ref_multiplier_out_o <= 10'(srf_pkg::VOL_DIVISOR + vol_sum);
      ref_divisor_o        <= srf_pkg::VOL_DIVISOR;
    end
  end

  assign display_on_o = disp_ctl_q[srf_pkg::DC_ON_POS];

  // Register read port, upper nibble reads zero
  logic [3:0] rd_nib;

  assign rd_nib = (rd_addr_q == srf_pkg::RA_NV_MODE) ? nv_mode_q :
                  (rd_addr_q == srf_pkg::RA_TRIM) ? trim_q : 4'h0;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      data_o <= 8'h00;
    end else if (ce_i) begin
      data_o <= {4'h0, rd_nib};
    end
  end

  assign data_oe_o = !s_cs_n && s_rs && !s_rd_n;

endmodule

// >>> logic/srf_frame_gen.sv
module srf_frame_gen (
  input  wire logic              clk_i,
  input  wire logic              srst_i,
  input  wire logic              ce_i,
  input  wire logic              src_tick_i,
  input  wire logic [3:0]        duty_code_i,
  input  wire srf_pkg::srf_grad_t grad_i,
  output logic                   line_tick_o,
  output logic                   frame_o,
  output logic [7:0]             line_idx_o
);

  logic [9:0] sub_q;
  logic [9:0] sub_last;
  logic [7:0] line_last;
  logic       sub_wrap;

  // One line lasts duty divider times gradation factor source ticks
  assign sub_last  = 10'(srf_pkg::duty_div(duty_code_i) * srf_pkg::grad_factor(grad_i)) - 10'd1;
  assign line_last = srf_pkg::duty_lines(duty_code_i) - 8'd1;
  assign sub_wrap  = src_tick_i && (sub_q >= sub_last);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sub_q       <= 10'h000;
      line_idx_o  <= 8'h00;
      line_tick_o <= 1'b0;
      frame_o     <= 1'b0;
    end else if (ce_i) begin
      line_tick_o <= sub_wrap;
      frame_o     <= sub_wrap && (line_idx_o >= line_last);
      if (src_tick_i) begin
        sub_q <= sub_wrap ? 10'h000 : sub_q + 10'd1;
      end
      if (sub_wrap) begin
        line_idx_o <= (line_idx_o >= line_last) ? 8'h00 : line_idx_o + 8'd1;
      end
    end
  end

endmodule

// >>> logic/srf_pkg.sv
package srf_pkg;

  // Bank select: a command with upper nibble F; its low three bits select the register bank
  localparam logic [3:0] CMD_BANK     = 4'hF;
  // Bank 0 commands
  localparam logic [2:0] BANK_DISP    = 3'h0;
  localparam logic [3:0] CMD_DISP_CTL = 4'h8;  // shift, gradation, display on
  localparam logic [3:0] CMD_LINE_LO  = 4'h4;  // start line bits 3..0
  localparam logic [3:0] CMD_LINE_HI  = 4'h5;  // start line bits 7..4
  // Bank 2 commands: volume code, high part first, valid after low part
  localparam logic [2:0] BANK_VOL     = 3'h2;
  localparam logic [3:0] CMD_VOL_HI   = 4'h8;
  localparam logic [3:0] CMD_VOL_LO   = 4'h9;
  // Bank 4 commands
  localparam logic [2:0] BANK_SYS     = 3'h4;
  localparam logic [3:0] CMD_START_COM = 4'h6;
  localparam logic [3:0] CMD_DUTY     = 4'h7;
  localparam logic [3:0] CMD_RD_ADDR  = 4'hD;
  // Bank 5 commands
  localparam logic [2:0] BANK_EXT     = 3'h5;
  localparam logic [3:0] CMD_NV_MODE  = 4'hA;
  localparam logic [3:0] CMD_TRIM     = 4'hB;

  // Internal read addresses
  localparam logic [3:0] RA_NV_MODE   = 4'hA;
  localparam logic [3:0] RA_TRIM      = 4'hB;

  // Reset values
  localparam logic [3:0] RST_NV_MODE  = 4'hC;
  localparam logic [3:0] RST_TRIM     = 4'h0;
  localparam logic [3:0] RST_RD_ADDR  = 4'hB;
  localparam logic [2:0] RST_BANK     = 3'h0;
  localparam logic [6:0] RST_VOLUME   = 7'h00;
  localparam logic [3:0] RST_DUTY     = 4'hF;

  // Field positions in the non-volatile mode nibble
  localparam int NV_OP_HI_POS  = 3;
  localparam int NV_OP_LO_POS  = 2;
  localparam int NV_SUPPLY_POS = 1;
  localparam int NV_BOOST_POS  = 0;
  // Field positions in the display control nibble
  localparam int DC_SHIFT_POS  = 3;
  localparam int DC_GRAD_POS   = 1;
  localparam int DC_ON_POS     = 0;

  typedef enum logic [1:0] {
    SRF_NV_READ    = 2'b00,
    SRF_NV_PROGRAM = 2'b01,
    SRF_NV_ERASE   = 2'b10,
    SRF_NV_RSVD    = 2'b11
  } srf_nv_op_t;

  typedef enum logic [1:0] {
    SRF_GRAD_VAR   = 2'b00,
    SRF_GRAD_4096  = 2'b01,
    SRF_GRAD_65K   = 2'b10,
    SRF_GRAD_256   = 2'b11
  } srf_grad_t;

  // Mapping, voltage and timing constants
  localparam logic [8:0] ROW_COUNT    = 9'd160;
  localparam logic [8:0] ICON_ROW_A   = 9'd160;
  localparam logic [8:0] ICON_ROW_B   = 9'd161;
  localparam logic [7:0] COM_STEP     = 8'd15;
  localparam logic [7:0] COM_COUNT    = 8'd130;
  localparam logic [9:0] VOL_DIVISOR  = 10'd381;
  localparam logic [7:0] DUTY_BASE    = 8'd10;
  localparam logic [7:0] DUTY_STEP    = 8'd8;
  localparam logic [7:0] DUTY_LIM_16  = 8'd18;
  localparam logic [7:0] DUTY_LIM_8   = 8'd34;
  localparam logic [7:0] DUTY_LIM_4   = 8'd82;
  localparam logic [5:0] GRAD_VAR_F   = 6'd47;
  localparam logic [5:0] GRAD_65K_F   = 6'd31;
  localparam logic [5:0] GRAD_4096_F  = 6'd15;
  localparam logic [5:0] GRAD_256_F   = 6'd7;

  // Duty code n selects 1/(10 + 8n), so 0 gives 1/10 and 15 gives 1/130
  function automatic logic [7:0] duty_lines(input logic [3:0] code);
    duty_lines = DUTY_BASE + DUTY_STEP * {4'h0, code};
  endfunction

  function automatic logic [4:0] duty_div(input logic [3:0] code);
    logic [7:0] d;
    d = duty_lines(code);
    if (d <= DUTY_LIM_16) duty_div = 5'd16;
    else if (d <= DUTY_LIM_8) duty_div = 5'd8;
    else if (d <= DUTY_LIM_4) duty_div = 5'd4;
    else duty_div = 5'd2;
  endfunction

  function automatic logic [5:0] grad_factor(input srf_grad_t g);
    unique case (g)
      SRF_GRAD_VAR:  grad_factor = GRAD_VAR_F;
      SRF_GRAD_65K:  grad_factor = GRAD_65K_F;
      SRF_GRAD_4096: grad_factor = GRAD_4096_F;
      SRF_GRAD_256:  grad_factor = GRAD_256_F;
    endcase
  endfunction

endpackage
